// File: bit_field_unit.sv
// Purpose: container alignment, bit and field extraction, bit set
// Assumes: lane_i is the byte lane offset in bits, b_i already
//          limited to the container width
// Notes:   purely combinational, results are registered by the caller
`timescale 1ns/1ps
module bit_field_unit (
    input  wire logic [31:0] rdata_i,
    input  wire logic [4:0]  lane_i,
    input  wire logic [1:0]  size_i,
    input  wire logic [4:0]  b_i,
    input  wire logic [3:0]  wm1_i,
    output logic             bit_o,
    output logic [31:0]      field_o,
    output logic [31:0]      setdata_o
);

    logic [31:0] cont_mask;
    logic [31:0] cont;
    logic [32:0] ones_wide;
    logic [31:0] fmask;
    logic [4:0]  set_pos;

    // container width from the access size
    always_comb begin
        case (size_i)
            2'h0:    cont_mask = 32'h000000ff;
            2'h1:    cont_mask = 32'h0000ffff;
            default: cont_mask = 32'hffffffff;
        endcase
    end

    // right-align the container and build the field mask
    assign cont      = (rdata_i >> lane_i) & cont_mask;
    assign ones_wide = (33'h1 << ({1'b0, wm1_i} + 5'h1)) - 33'h1;
    // mask bits past the container are dropped
    assign fmask     = (ones_wide[31:0] << b_i) & cont_mask;
    assign field_o   = cont & fmask;
    assign bit_o     = cont[b_i];
    // set the bit in place on its own byte lane
    assign set_pos   = lane_i + b_i;
    assign setdata_o = rdata_i | (32'h1 << set_pos);

endmodule

// File: decorated_load_bit_engine.sv
// Purpose: decorated load engine between core master and memory slaves
// Assumes: AHB-Lite on both sides, one clock, slave idle answers ready
// Notes:   decorated stores and load-and-clear pass with decoration
//          removed; their own engines sit elsewhere
// Operation
// - load-and-set returns old bit right-justified and writes it back set
// - container size follows the read size: byte, halfword or word
// - address bits 28:26 = 011 select load-and-set, 25:21 give bit
// - bits 30:29 pick sram or peripheral; decoration stripped on forward
// - cycle x forwards read; x+1 recirculates captured address as write
// - cycle x+2 returns bit and drives registered write data; one stall
// - field extract returns right-justified field and never writes
// - word field extract width is at most sixteen bits
// - bit 28 selects field extract; 27:23 start, 22:19 width minus one
// - field extract address is masked to a 19-bit offset
// - field mask is w+1 ones shifted by b, and-ed then shifted back
// - field beyond the container is cut at the container edge
// - field extract idles the slave at x+1, returns shifted data x+2
// - peripheral space is 129 slots of 4 KB each
// - 0x4000_0000 to 0x4007_FFFF pass as plain peripheral accesses
// - the two illegal peripheral ranges end with an error response
// - gpio reachable at both bases, same physical slot
// - plain accesses at the standard gpio base reach the gpio slot
// - decorated logic and single-bit ops accepted at 0x44-0x4F
// - field insert and extract reach gpio only via the alternate base
// - slave wait states pass back to the master cycle for cycle
`timescale 1ns/1ps
module decorated_load_bit_engine (
    input  wire logic        clk_sys_i,
    input  wire logic        rst_i,
    input  wire logic [31:0] m_haddr_i,
    input  wire logic [1:0]  m_htrans_i,
    input  wire logic        m_hwrite_i,
    input  wire logic [2:0]  m_hsize_i,
    input  wire logic [31:0] m_hwdata_i,
    output logic      [31:0] m_hrdata_o,
    output logic             m_hready_o,
    output logic             m_hresp_o,
    output logic      [31:0] s_haddr_o,
    output logic      [1:0]  s_htrans_o,
    output logic             s_hwrite_o,
    output logic      [2:0]  s_hsize_o,
    output logic      [31:0] s_hwdata_o,
    output logic             s_hready_o,
    input  wire logic [31:0] s_hrdata_i,
    input  wire logic        s_hready_i,
    input  wire logic        s_hresp_i
);

    dlb_pkg::state_t state_ff;
    dlb_pkg::state_t nxt_state;
    logic [31:0] cap_addr_ff;
    logic [2:0]  cap_size_ff;
    logic [4:0]  cap_lane_ff;
    logic [4:0]  cap_b_ff;
    logic [3:0]  cap_w_ff;
    logic        bit_ff;
    logic [31:0] setdata_ff;
    logic [31:0] field_ff;
    logic [1:0]  space;
    logic [2:0]  op;
    logic        in_space;
    logic        dec;
    logic        is_las;
    logic        is_bfx;
    logic        illegal;
    logic [31:0] strip;
    logic [31:0] fwd_addr;
    logic [4:0]  bmask;
    logic [4:0]  las_b;
    logic [4:0]  bfx_b;
    logic        addr_en;
    logic        acc;
    logic        fu_bit;
    logic [31:0] fu_field;
    logic [31:0] fu_set;

    // ************************************************************
    // address decode
    // ************************************************************

    // decoration fields of the incoming address phase
    assign space    = m_haddr_i[dlb_pkg::SPACE_LSB +: 2];
    assign op       = m_haddr_i[dlb_pkg::OP_LSB +: 3];
    assign in_space = !m_haddr_i[31] && (space == dlb_pkg::SPACE_SRAM ||
                      space == dlb_pkg::SPACE_PERI);
    assign dec      = in_space && (op != dlb_pkg::PLAIN_CODE);
    assign is_las   = dec && (op == dlb_pkg::LAS_CODE) && !m_hwrite_i;
    assign is_bfx   = dec && m_haddr_i[dlb_pkg::BFX_FLAG_POS]
                      && !m_hwrite_i;

    // only slot 0x00-0x7f and the gpio slot are mapped
    assign illegal  = in_space && !dec && (space == dlb_pkg::SPACE_PERI)
                      && (m_haddr_i[25:dlb_pkg::LEGAL_LSB] != dlb_pkg::LEGAL_OFS)
                      && (m_haddr_i[25:dlb_pkg::SLOT_LSB]
                          != dlb_pkg::GPIO_SLOT_OFS);

    // decoration removed, bit 19 dropped for field extracts
    always_comb begin
        if (!dec) begin
            strip = m_haddr_i;
        end else if (m_haddr_i[dlb_pkg::BFX_FLAG_POS]) begin
            strip = m_haddr_i & dlb_pkg::BFX_ADDR_MASK;
        end else begin
            strip = m_haddr_i & dlb_pkg::LAS_ADDR_MASK;
        end
    end

    // standard gpio page folds onto the physical slot
    assign fwd_addr = (strip[31:dlb_pkg::SLOT_LSB] == dlb_pkg::GPIO_STD_PAGE)
                      ? {dlb_pkg::GPIO_ALT_PAGE, strip[11:0]} : strip;

    // bit position limited to the container width
    assign bmask = {m_hsize_i == dlb_pkg::HSIZE_WORD, m_hsize_i != 3'h0,
                    3'h7};
    assign las_b = m_haddr_i[dlb_pkg::LAS_B_LSB +: 5] & bmask;
    assign bfx_b = m_haddr_i[dlb_pkg::BFX_B_LSB +: 5] & bmask;

    // address phases are taken only where the master sees ready
    assign addr_en = (state_ff == dlb_pkg::ST_PASS)
                  || (state_ff == dlb_pkg::ST_LAS_WR)
                  || (state_ff == dlb_pkg::ST_BFX_RET)
                  || (state_ff == dlb_pkg::ST_ERR2);
    assign acc     = addr_en && m_hready_o && m_htrans_i[1];

    // ************************************************************
    // sequencer
    // ************************************************************

    // next state of the decorated access sequence
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            dlb_pkg::ST_PASS, dlb_pkg::ST_LAS_WR,
            dlb_pkg::ST_BFX_RET, dlb_pkg::ST_ERR2: begin
                if (acc) begin
                    if (illegal) begin
                        nxt_state = dlb_pkg::ST_ERR1;
                    end else if (is_las) begin
                        nxt_state = dlb_pkg::ST_LAS_RD;
                    end else if (is_bfx) begin
                        nxt_state = dlb_pkg::ST_BFX_RD;
                    end else begin
                        nxt_state = dlb_pkg::ST_PASS;
                    end
                end else if (m_hready_o) begin
                    nxt_state = dlb_pkg::ST_PASS;
                end
            end
            dlb_pkg::ST_LAS_RD: begin
                if (s_hready_i) begin
                    nxt_state = dlb_pkg::ST_LAS_WR;
                end
            end
            dlb_pkg::ST_BFX_RD: begin
                if (s_hready_i) begin
                    nxt_state = dlb_pkg::ST_BFX_RET;
                end
            end
            dlb_pkg::ST_ERR1: nxt_state = dlb_pkg::ST_ERR2;
            default:          nxt_state = dlb_pkg::ST_PASS;
        endcase
    end

    // state register
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            state_ff <= dlb_pkg::ST_PASS;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // capture address and attributes in cycle x
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            cap_addr_ff <= dlb_pkg::WORD_RST;
            cap_size_ff <= 3'h0;
            cap_lane_ff <= dlb_pkg::FIELD_RST;
            cap_b_ff    <= dlb_pkg::FIELD_RST;
            cap_w_ff    <= 4'h0;
        end else if (acc) begin
            cap_addr_ff <= fwd_addr;
            cap_size_ff <= m_hsize_i;
            cap_lane_ff <= {m_haddr_i[1:0], 3'h0};
            cap_b_ff    <= is_bfx ? bfx_b : las_b;
            cap_w_ff    <= m_haddr_i[dlb_pkg::BFX_W_LSB +: 4];
        end
    end

    // ************************************************************
    // data path
    // ************************************************************
    bit_field_unit u_field (
        .rdata_i   (s_hrdata_i),
        .lane_i    (cap_lane_ff),
        .size_i    (cap_size_ff[1:0]),
        .b_i       (cap_b_ff),
        .wm1_i     (cap_w_ff),
        .bit_o     (fu_bit),
        .field_o   (fu_field),
        .setdata_o (fu_set)
    );

    // read, modify and register in the first data phase
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            bit_ff     <= 1'b0;
            setdata_ff <= dlb_pkg::WORD_RST;
            field_ff   <= dlb_pkg::WORD_RST;
        end else if (s_hready_i) begin
            if (state_ff == dlb_pkg::ST_LAS_RD) begin
                bit_ff     <= fu_bit;
                setdata_ff <= fu_set;
            end
            if (state_ff == dlb_pkg::ST_BFX_RD) begin
                field_ff <= fu_field;
            end
        end
    end

    // ************************************************************
    // slave side
    // ************************************************************

    // recirculated write, idle slot, or the master's own address
    always_comb begin
        s_haddr_o  = cap_addr_ff;
        s_hsize_o  = cap_size_ff;
        s_hwrite_o = 1'b0;
        s_htrans_o = dlb_pkg::HTRANS_IDLE;
        case (state_ff)
            dlb_pkg::ST_LAS_RD: begin
                s_hwrite_o = 1'b1;
                s_htrans_o = dlb_pkg::HTRANS_NONSEQ;
            end
            dlb_pkg::ST_BFX_RD, dlb_pkg::ST_ERR1: begin
                s_htrans_o = dlb_pkg::HTRANS_IDLE;
            end
            default: begin
                s_haddr_o  = fwd_addr;
                s_hsize_o  = m_hsize_i;
                s_hwrite_o = m_hwrite_i;
                s_htrans_o = illegal ? dlb_pkg::HTRANS_IDLE
                                     : m_htrans_i;
            end
        endcase
    end

    // registered set data goes out in the write data phase
    assign s_hwdata_o = (state_ff == dlb_pkg::ST_LAS_WR) ? setdata_ff
                                                         : m_hwdata_i;
    assign s_hready_o = (state_ff == dlb_pkg::ST_LAS_RD ||
                         state_ff == dlb_pkg::ST_BFX_RD) ? s_hready_i
                                                         : m_hready_o;

    // ************************************************************
    // master side
    // ************************************************************

    // ready, response and read data back to the core
    always_comb begin
        m_hready_o = s_hready_i;
        m_hresp_o  = s_hresp_i;
        m_hrdata_o = s_hrdata_i;
        case (state_ff)
            dlb_pkg::ST_LAS_RD, dlb_pkg::ST_BFX_RD: begin
                m_hready_o = 1'b0;
                m_hresp_o  = 1'b0;
            end
            dlb_pkg::ST_LAS_WR: begin
                m_hrdata_o = {31'h0, bit_ff};
            end
            dlb_pkg::ST_BFX_RET: begin
                m_hready_o = 1'b1;
                m_hresp_o  = 1'b0;
                m_hrdata_o = field_ff >> cap_b_ff;
            end
            dlb_pkg::ST_ERR1: begin
                m_hready_o = 1'b0;
                m_hresp_o  = 1'b1;
            end
            dlb_pkg::ST_ERR2: begin
                m_hready_o = 1'b1;
                m_hresp_o  = 1'b1;
            end
            default: begin
                m_hready_o = s_hready_i;
            end
        endcase
    end

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);

    sequence las_take;
        acc && is_las && !illegal;
    endsequence

    sequence bfx_take;
        acc && is_bfx && !is_las;
    endsequence

    sequence bfx_done;
        state_ff == dlb_pkg::ST_BFX_RET && m_hready_o && !m_hresp_o;
    endsequence

    a_las_addr_strip: assert property (
        las_take |-> s_haddr_o[28:20] == 9'h0 && !s_hwrite_o
                     && s_htrans_o == dlb_pkg::HTRANS_NONSEQ)
        else $error("load-and-set read not forwarded undecorated");

    a_las_rmw_order: assert property (
        las_take |=> (state_ff == dlb_pkg::ST_LAS_RD && s_hwrite_o
                      && s_haddr_o == $past(fwd_addr)) ##[1:16]
                     (state_ff == dlb_pkg::ST_LAS_WR))
        else $error("load-and-set write not recirculated");

    a_las_bit_return: assert property (
        state_ff == dlb_pkg::ST_LAS_WR |->
            m_hrdata_o[31:1] == 31'h0
            && s_hwdata_o[cap_lane_ff + cap_b_ff] == 1'b1)
        else $error("load-and-set data phase wrong");

    a_las_wait_pass: assert property (
        state_ff == dlb_pkg::ST_LAS_WR |-> m_hready_o == s_hready_i)
        else $error("slave wait not passed to master");

    a_bfx_no_write: assert property (
        bfx_take |=> (state_ff == dlb_pkg::ST_BFX_RD
                      && s_htrans_o == dlb_pkg::HTRANS_IDLE
                      && !m_hready_o) ##[1:16] bfx_done)
        else $error("field extract sequence broken");

    a_bfx_field_width: assert property (
        state_ff == dlb_pkg::ST_BFX_RET |->
            (m_hrdata_o >> ({1'b0, cap_w_ff} + 5'h1)) == 32'h0)
        else $error("extracted field wider than specified");

    a_illegal_error: assert property (
        acc && illegal |-> s_htrans_o == dlb_pkg::HTRANS_IDLE
        ##1 (m_hresp_o && !m_hready_o && s_htrans_o == dlb_pkg::HTRANS_IDLE)
        ##1 (m_hresp_o && m_hready_o))
        else $error("illegal reference not error terminated");

    a_gpio_alias: assert property (
        m_htrans_i[1] && addr_en && !dec &&
        m_haddr_i[31:dlb_pkg::SLOT_LSB] == dlb_pkg::GPIO_STD_PAGE |->
            s_haddr_o[31:dlb_pkg::SLOT_LSB] == dlb_pkg::GPIO_ALT_PAGE)
        else $error("gpio alias not folded onto its slot");

endmodule

// File: dlb_pkg.sv
// Purpose: shared constants and state type for the decorated load engine
// Assumes: 32-bit AHB-Lite address and data paths
// Notes:   field positions index the decorated master address
package dlb_pkg;

    // ************************************************************
    // address decoration
    // ************************************************************
    localparam logic [31:0] LAS_ADDR_MASK = 32'he00fffff;
    localparam logic [31:0] BFX_ADDR_MASK = 32'he007ffff;
    localparam logic [2:0]  LAS_CODE      = 3'h3;
    localparam logic [2:0]  PLAIN_CODE    = 3'h0;
    localparam logic [1:0]  SPACE_SRAM    = 2'h1;
    localparam logic [1:0]  SPACE_PERI    = 2'h2;
    localparam int          OP_LSB        = 26;
    localparam int          SPACE_LSB     = 29;
    localparam int          BFX_FLAG_POS  = 28;
    localparam int          LAS_B_LSB     = 21;
    localparam int          BFX_B_LSB     = 23;
    localparam int          BFX_W_LSB     = 19;
    localparam int          SLOT_LSB      = 12;
    localparam int          LEGAL_LSB     = 19;

    // ************************************************************
    // peripheral slots and gpio aliases
    // ************************************************************
    localparam logic [19:0] GPIO_STD_PAGE = 20'h400ff;
    localparam logic [19:0] GPIO_ALT_PAGE = 20'h4000f;
    localparam logic [13:0] GPIO_SLOT_OFS = 14'h00ff;
    localparam logic [6:0]  LEGAL_OFS     = 7'h00;

    // ************************************************************
    // bus encodings and reset values
    // ************************************************************
    localparam logic [1:0]  HTRANS_IDLE   = 2'h0;
    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0]  HSIZE_WORD    = 3'h2;
    localparam logic [31:0] WORD_RST      = 32'h0;
    localparam logic [4:0]  FIELD_RST     = 5'h0;
    localparam int          ERR_CYCLES    = 2;

    typedef enum logic [2:0] {
        ST_PASS    = 3'h0,
        ST_LAS_RD  = 3'h1,
        ST_LAS_WR  = 3'h2,
        ST_BFX_RD  = 3'h3,
        ST_BFX_RET = 3'h4,
        ST_ERR1    = 3'h5,
        ST_ERR2    = 3'h6
    } state_t;

endpackage

// File: mem_slave_model.sv
// Purpose: behavioural memory slave behind the decorated load engine
// Assumes: ahb-lite slave, 16-word memory aliased on addr[5:2]
// Notes:   wait_i sets wait states per transfer; idle read bus toggles
`timescale 1ns/1ps
module mem_slave_model (
    input  wire logic        clk_sys_i,
    input  wire logic        rst_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    input  wire logic [3:0]  wait_i,
    output logic      [31:0] hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o
);
    logic [31:0] mem [16];
    logic        busy_ff, wr_ff, tog_ff;
    logic [3:0]  cnt_ff;
    logic [2:0]  size_ff;
    logic [31:0] addr_ff, wr_addr_ff, lane_m;
    int          acc_cnt_ff, wr_cnt_ff;

    // ************************************************************
    // data phase answer
    // ************************************************************
    // byte lanes touched by the captured transfer
    always_comb begin
        case (size_ff)
            3'h0: lane_m = 32'hff << {addr_ff[1:0], 3'h0};
            3'h1: lane_m = 32'hffff << {addr_ff[1], 4'h0};
            default: lane_m = 32'hffffffff;
        endcase
    end
    // read data only while a read completes, else a moving pattern
    assign hreadyout_o = !busy_ff || (cnt_ff == 4'h0);
    assign hresp_o     = 1'b0;
    assign hrdata_o    = (busy_ff && cnt_ff == 4'h0 && !wr_ff) ?
                         mem[addr_ff[5:2]] : {16{tog_ff, ~tog_ff}};

    // address capture, wait countdown and write completion
    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            busy_ff    <= 1'b0;
            cnt_ff     <= 4'h0;
            tog_ff     <= 1'b0;
            acc_cnt_ff <= 0;
            wr_cnt_ff  <= 0;
        end else begin
            tog_ff <= ~tog_ff;
            if (busy_ff && cnt_ff != 4'h0) begin
                cnt_ff <= cnt_ff - 4'h1;
            end else if (busy_ff) begin
                busy_ff <= 1'b0;
                if (wr_ff) begin
                    mem[addr_ff[5:2]] <= (mem[addr_ff[5:2]] & ~lane_m) |
                                         (hwdata_i & lane_m);
                    wr_cnt_ff  <= wr_cnt_ff + 1;
                    wr_addr_ff <= addr_ff;
                end
            end
            if (hready_i && htrans_i[1] && hreadyout_o) begin
                busy_ff    <= 1'b1;
                cnt_ff     <= wait_i;
                addr_ff    <= haddr_i;
                wr_ff      <= hwrite_i;
                size_ff    <= hsize_i;
                acc_cnt_ff <= acc_cnt_ff + 1;
            end
        end
    end
endmodule

// File: testbench.sv
// Purpose: self-checking bench for the decorated load engine
// Assumes: memory slave model on the slave side, no slave errors
// Notes:   each scenario task drives one master transfer and judges it
`timescale 1ns/1ps
module testbench;
    logic        clk_sys_i, rst_i, m_hwrite, m_hready_o, m_hresp_o;
    logic [31:0] m_haddr, m_hwdata, m_hrdata_o, s_haddr_o, s_hwdata_o;
    logic [31:0] s_hrdata_i, rd, fwd_addr;
    logic [1:0]  m_htrans, s_htrans_o, fwd_trans;
    logic [2:0]  m_hsize, s_hsize_o;
    logic        s_hwrite_o, s_hready_o, s_hready_i, s_hresp_i, resp, resp1;
    logic [3:0]  wait_q;
    int          n_errors, n_checks, cyc, acc0, wr0;

    decorated_load_bit_engine i_decorated_load_bit_engine (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .m_haddr_i(m_haddr),
        .m_htrans_i(m_htrans), .m_hwrite_i(m_hwrite), .m_hsize_i(m_hsize),
        .m_hwdata_i(m_hwdata), .m_hrdata_o(m_hrdata_o),
        .m_hready_o(m_hready_o), .m_hresp_o(m_hresp_o),
        .s_haddr_o(s_haddr_o), .s_htrans_o(s_htrans_o),
        .s_hwrite_o(s_hwrite_o), .s_hsize_o(s_hsize_o),
        .s_hwdata_o(s_hwdata_o), .s_hready_o(s_hready_o),
        .s_hrdata_i(s_hrdata_i), .s_hready_i(s_hready_i),
        .s_hresp_i(s_hresp_i));
    mem_slave_model i_mem_slave_model (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .haddr_i(s_haddr_o),
        .htrans_i(s_htrans_o), .hwrite_i(s_hwrite_o), .hsize_i(s_hsize_o),
        .hwdata_i(s_hwdata_o), .hready_i(s_hready_o), .wait_i(wait_q),
        .hrdata_o(s_hrdata_i), .hreadyout_o(s_hready_i),
        .hresp_o(s_hresp_i));

    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic check(input logic [31:0] seen, exp, input string msg);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: %s seen %h expected %h",
                     $time, msg, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // one master transfer; cyc counts data phase cycles
    task automatic xfer(input logic [31:0] a, input logic wr,
                        input logic [2:0] sz, input logic [31:0] wd,
                        input logic [3:0] wt);
        @(posedge clk_sys_i);
        m_haddr <= a;
        m_htrans <= dlb_pkg::HTRANS_NONSEQ;
        m_hwrite <= wr;
        m_hsize <= sz;
        wait_q <= wt;
        @(negedge clk_sys_i);
        fwd_addr = s_haddr_o;
        fwd_trans = s_htrans_o;
        acc0 = i_mem_slave_model.acc_cnt_ff;
        wr0 = i_mem_slave_model.wr_cnt_ff;
        check(32'(m_hready_o), 32'h1, "addr phase");
        @(posedge clk_sys_i);
        m_htrans <= dlb_pkg::HTRANS_IDLE;
        m_hwdata <= wd;
        cyc = 0;
        do begin
            @(negedge clk_sys_i);
            cyc++;
            if (cyc == 1) resp1 = m_hresp_o;
        end while (m_hready_o !== 1'b1 && cyc < 40);
        if (cyc >= 40) begin
            n_errors++;
            $display("mismatch at %0t: transfer hung", $time);
            complete_run();
        end
        rd = m_hrdata_o;
        resp = m_hresp_o;
        @(posedge clk_sys_i);
        #1;
    endtask
    // gpio page seen on the slave side is the alternate slot
    function automatic logic [31:0] slot(input logic [31:0] a);
        slot = a;
        if (a[31:12] == 20'h400ff) slot[31:12] = 20'h4000f;
    endfunction

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic las_case(input logic [31:0] base, input logic [19:0] off,
                            input logic [2:0] sz, input logic [4:0] b,
                            input logic [31:0] w0, input logic [3:0] wt);
        logic [4:0]  pos;
        logic [31:0] ea;
        pos = {off[1:0], 3'h0} + b;
        ea = slot(base | 32'(off));
        i_mem_slave_model.mem[ea[5:2]] = w0;
        xfer(base | (32'h3 << 26) | (32'(b) << 21) | 32'(off), 1'b0, sz,
             32'h0, wt);
        check(fwd_addr, ea, "las read address");
        check(rd, {31'h0, w0[pos]}, "las old bit");
        check(32'(cyc), 32'(2 + 2 * wt), "las cycles");
        check(32'(resp), 32'h0, "las response");
        check(i_mem_slave_model.mem[ea[5:2]], w0 | (32'h1 << pos),
              "las write back");
        check(i_mem_slave_model.wr_addr_ff, ea, "las write address");
        check(32'(i_mem_slave_model.wr_cnt_ff - wr0), 32'h1, "las writes");
    endtask
    task automatic bfx_case(input logic [31:0] base, input logic [18:0] off,
                            input logic [2:0] sz, input logic [4:0] b,
                            input logic [3:0] w, input logic [31:0] w0,
                            input logic [3:0] wt);
        logic [31:0] cont;
        cont = w0 >> {off[1:0], 3'h0};
        if (sz == 3'h0) cont = cont & 32'hff;
        if (sz == 3'h1) cont = cont & 32'hffff;
        i_mem_slave_model.mem[off[5:2]] = w0;
        xfer(base | (32'h1 << 28) | (32'(b) << 23) | (32'(w) << 19) |
             32'(off), 1'b0, sz, 32'h0, wt);
        check(fwd_addr, base | 32'(off), "extract address");
        check(rd, (cont >> b) & ((32'h1 << (32'(w) + 1)) - 32'h1),
              "extract field");
        check(32'(cyc), 32'(2 + wt), "extract cycles");
        check(32'(i_mem_slave_model.acc_cnt_ff - acc0), 32'h1,
              "extract accesses");
        check(32'(i_mem_slave_model.wr_cnt_ff - wr0), 32'h0, "extract writes");
    endtask
    task automatic pass_case(input logic [31:0] a, input logic wr,
                             input logic [31:0] ea, input logic [3:0] wt);
        i_mem_slave_model.mem[ea[5:2]] = ea ^ 32'h5a5a0000;
        xfer(a, wr, dlb_pkg::HSIZE_WORD, ~ea, wt);
        check(fwd_addr, ea, "plain address");
        check(32'(resp), 32'h0, "plain response");
        check(32'(cyc), 32'(1 + wt), "plain cycles");
        if (!wr) check(rd, ea ^ 32'h5a5a0000, "plain data");
        else check(i_mem_slave_model.mem[ea[5:2]], ~ea, "wdata");
    endtask
    task automatic err_case(input logic [31:0] a);
        xfer(a, 1'b0, dlb_pkg::HSIZE_WORD, 32'h0, 4'h0);
        check(32'(fwd_trans), 32'(dlb_pkg::HTRANS_IDLE), "error forward");
        check({resp1, resp}, 32'h3, "error response");
        check(32'(cyc), 32'(dlb_pkg::ERR_CYCLES), "error cycles");
        check(32'(i_mem_slave_model.acc_cnt_ff - acc0), 32'h0,
              "error accesses");
    endtask

    // ************************************************************
    // clock and main sequence
    // ************************************************************
    initial begin
        clk_sys_i = 1'b0;
        forever #25 clk_sys_i = ~clk_sys_i;
    end
    initial begin
        rst_i = 1'b1;
        m_haddr = 32'h0;
        m_htrans = dlb_pkg::HTRANS_IDLE;
        m_hwrite = 1'b0;
        m_hsize = dlb_pkg::HSIZE_WORD;
        m_hwdata = 32'h0;
        wait_q = 4'h0;
        n_errors = 0;
        n_checks = 0;
        repeat (16) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        las_case(32'h20000000, 20'h00003, 3'h0, 5'h5, 32'h9a5a3c00, 4'h0);
        las_case(32'h40000000, 20'h00412, 3'h1, 5'hf, 32'h80001234, 4'h0);
        las_case(32'h40000000, 20'h00008, 3'h2, 5'h0, 32'hfffffffe, 4'h2);
        las_case(32'h40000000, 20'hff004, 3'h2, 5'h1f, 32'h7fffffff, 4'h0);
        bfx_case(32'h20000000, 19'h00100, 3'h2, 5'h4, 4'hf, 32'h12345678,
                 4'h0);
        bfx_case(32'h40000000, 19'h00006, 3'h1, 5'h9, 4'h9, 32'habcd0000,
                 4'h2);
        bfx_case(32'h40000000, 19'h0f003, 3'h0, 5'h7, 4'h0, 32'h80000000,
                 4'h1);
        pass_case(32'h40001230, 1'b0, 32'h40001230, 4'h0);
        pass_case(32'h4007fffc, 1'b0, 32'h4007fffc, 4'h2);
        pass_case(32'h400ff010, 1'b0, 32'h4000f010, 4'h0);
        pass_case(32'h4800f020, 1'b1, 32'h4000f020, 4'h0);
        pass_case(32'h480ff020, 1'b1, 32'h4000f020, 4'h1);
        err_case(32'h40080000);
        err_case(32'h400feffc);
        err_case(32'h40100000);
        err_case(32'h43fffffc);
        pass_case(32'h400ff000, 1'b0, 32'h4000f000, 4'h0);
        complete_run();
    end
endmodule
